// File: hw/ifq_defines.svh
// Constants for the IF frequency window qualifier
`ifndef IFQ_DEFINES_SVH
`define IFQ_DEFINES_SVH

// Reference and gate timing
`define IFQ_REF_PERIOD_NS   1000
`define IFQ_CYCLE_NS        8000
`define IFQ_GATE_NS         4000
`define IFQ_CLEAR_DELAY_NS  1000
`define IFQ_REF_DIV         (`IFQ_CYCLE_NS / `IFQ_REF_PERIOD_NS)
`define IFQ_GATE_PHASES     (`IFQ_GATE_NS / `IFQ_REF_PERIOD_NS)
`define IFQ_CLEAR_PHASES    (`IFQ_CLEAR_DELAY_NS / `IFQ_REF_PERIOD_NS)
`define IFQ_PRESCALE        4

// Count windows, one count per MHz of IF
`define IFQ_NARROW_LO       8'h30
`define IFQ_NARROW_HI       8'h66
`define IFQ_WIDE_LO         8'h16
`define IFQ_WIDE_HI         8'h80

// Data bus bit positions
`define IFQ_BIT_VALID       7
`define IFQ_BIT_NARROW_N    6
`define IFQ_BIT_OVERLOAD    4

// Register port offsets and reset values
`define IFQ_REG_IRQ_STATUS  2'h0
`define IFQ_REG_IRQ_MASK    2'h1
`define IFQ_REG_LIVE        2'h2
`define IFQ_IRQ_MASK_RESET  3'h0

// Interrupt status bit positions
`define IFQ_IRQ_NARROW      0
`define IFQ_IRQ_INVALID     1
`define IFQ_IRQ_OVERLOAD    2

`endif

// File: hw/ifq_pkg.sv
// Types shared by the IF frequency window qualifier
package ifq_pkg;

    // Held qualifier pair
    typedef struct packed {
        logic wide;
        logic narrow;
    } ifq_qual_type;

    // Timing pulses from the reference divider
    typedef struct packed {
        logic       gate;
        logic       load;
        logic       clear;
        logic [2:0] phase;
    } ifq_timing_type;

    // Measurement progress within one 8 us cycle
    typedef enum logic [1:0] {
        ST_COUNT,
        ST_HOLD,
        ST_IDLE
    } ifq_state_type;

endpackage

// File: hw/ifq_prescaler.sv
// Divide-by-four IF prescaler built from two binaries
`timescale 1ns/1ps
`default_nettype none
module ifq_prescaler
    import ifq_pkg::*;
(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    // IF in, prescaled tick out
    input  wire logic if_i,
    output logic      tick_o
);
    logic if_q;
    logic bin0;
    logic bin1;
    logic if_rise;
    logic bin0_fall;

    assign if_rise   = if_i & ~if_q;
    assign bin0_fall = if_rise & bin0;

    // Two cascaded divide-by-two stages
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            if_q <= 1'b0;
            bin0 <= 1'b0;
            bin1 <= 1'b0;
        end else begin
            if_q <= if_i;
            if (if_rise) bin0 <= ~bin0;
            if (bin0_fall) bin1 <= ~bin1;
        end
    end

    // One tick for every fourth IF edge
    assign tick_o = bin0_fall & bin1;
endmodule
`default_nettype wire

// File: hw/ifq_timebase.sv
// Reference divider giving gate, load and clear timing
`timescale 1ns/1ps
`default_nettype none
`include "ifq_defines.svh"
module ifq_timebase
    import ifq_pkg::*;
#(
    parameter int DIV      = `IFQ_REF_DIV,
    parameter int OPEN     = `IFQ_GATE_PHASES,
    parameter int CLR_WAIT = `IFQ_CLEAR_PHASES
) (
    // Clock and reset
    input  wire logic     clk_i,
    input  wire logic     sys_rst_i,
    // 1 MHz reference, timing out
    input  wire logic     ref_i,
    output var ifq_timing_type timing_o
);
    localparam logic [2:0] LOAD_PH = 3'(OPEN);
    localparam logic [2:0] CLR_PH  = 3'(OPEN + CLR_WAIT);
    localparam logic [2:0] LAST_PH = 3'(DIV - 1);

    generate
        if (DIV != 8 || OPEN < 1 || OPEN + CLR_WAIT >= DIV) begin : g_bad
            $error("ifq_timebase: unsupported divider settings");
        end
    endgenerate

    logic       ref_q;
    logic       ref_rise;
    logic [2:0] phase;

    assign ref_rise = ref_i & ~ref_q;

    // Phase advances once per reference period
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ref_q <= 1'b0;
            phase <= 3'h0;
        end else begin
            ref_q <= ref_i;
            if (ref_rise) phase <= (phase == LAST_PH) ? 3'h0 : phase + 3'h1;
        end
    end

    // Gate is open for the first phases of the cycle
    assign timing_o.gate  = (phase < LOAD_PH); // see R2
    assign timing_o.load  = ref_rise & (phase == LOAD_PH - 3'h1);
    assign timing_o.clear = ref_rise & (phase == CLR_PH - 3'h1);
    assign timing_o.phase = phase;
endmodule
`default_nettype wire

// File: hw/ifq_top.sv
// IF frequency window qualifier with detector bus port
//
// Notes on behaviour
// R1: IF divided by four before counting
// R2: Gate from 1 MHz reference divided by eight
// R3: Count prescaled edges only while gate open
// R4: Measurement repeats every 8 us, free running
// R5: Narrow qualifier true for counts 48 to 102
// R6: Wide qualifier true for 22 to 128 MHz; code also holds it false while input_power_ok_i is low
// R7: Both qualifiers captured once per cycle
// R8: Counter cleared 1 us after capture
// R9: Read strobe enables data driver, else released
// R10: D6 carries narrow qualifier, low in range
// R11: Arm strobe sets latch if wide held true
// R12: Wide held false resets latch to invalid
// R13: D7 carries validity latch, low means invalid
// R14: Host restarts sweep 100 kHz lower if invalid
// R15: D4 carries overload flag, high above +5 dBm
// R16: Reset clears counter, divider, hold, latch invalid
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "ifq_defines.svh"
module ifq_top
    import ifq_pkg::*;
#(
    parameter int CNT_W = 8
) (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    // Signal side
    input  wire logic       if_i,
    input  wire logic       ref_1mhz_i,
    input  wire logic       input_power_ok_i,
    input  wire logic       input_overload_flag_i,
    // Detector data bus port
    input  wire logic       detector_read_strobe_i,
    input  wire logic       detector_arm_strobe_i,
    output logic [7:0]      data_o,
    output logic            data_oe_o,
    // Register port
    input  wire logic [1:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic [7:0]      reg_rdata_o,
    // Interrupt
    output logic            irq_o
);
    generate
        if (CNT_W != 8) begin : g_bad_width
            $error("ifq_top: count width must hold 128 and saturate at 8 bits");
        end
    endgenerate

    localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

    // Window test, used for both qualifiers
    function automatic logic in_window(input logic [CNT_W-1:0] cnt,
                                       input logic [CNT_W-1:0] lo,
                                       input logic [CNT_W-1:0] hi);
        in_window = (cnt >= lo) && (cnt <= hi);
    endfunction

    logic             tick;
    ifq_timing_type   timing;
    logic [CNT_W-1:0] count;
    ifq_qual_type     next_qual;
    ifq_qual_type     qual_hold;
    logic             valid;
    logic             valid_q;
    logic             narrow_q;
    logic             ovl_q;
    ifq_state_type    state;
    ifq_state_type    next_state;
    logic [2:0]       irq_status;
    logic [2:0]       irq_mask;
    logic [2:0]       irq_event;
    logic [2:0]       irq_clear;

    // Prescaler ahead of the gated counter
    ifq_prescaler u_prescaler (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .if_i      (if_i),
        .tick_o    (tick)
    ); // see R1

    // Reference divider, runs without any host command
    ifq_timebase u_timebase (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .ref_i     (ref_1mhz_i),
        .timing_o  (timing)
    ); // see R2 see R4

    // Gated binary counter; saturates so a very high IF never wraps into range
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            count <= '0; // see R16
        end else if (timing.clear) begin
            count <= '0; // see R8
        end else if (timing.gate && tick && count != CNT_MAX) begin
            count <= count + CNT_W'(1); // see R3
        end
    end

    // Decode; lost input power forbids a valid wide result
    always_comb begin
        next_qual.narrow = in_window(count, `IFQ_NARROW_LO, `IFQ_NARROW_HI); // see R5
        next_qual.wide   = in_window(count, `IFQ_WIDE_LO, `IFQ_WIDE_HI)
                           && input_power_ok_i; // see R6
    end

    // Qualifier holding register, loaded once per cycle
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            qual_hold <= '0; // see R16
        end else if (timing.load) begin
            qual_hold <= next_qual; // see R7
        end
    end

    // Measurement progress, for observation only
    always_comb begin
        case (state)
            ST_COUNT: next_state = timing.load ? ST_HOLD : ST_COUNT;
            ST_HOLD:  next_state = timing.clear ? ST_IDLE : ST_HOLD;
            ST_IDLE:  next_state = timing.gate ? ST_COUNT : ST_IDLE;
            default:  next_state = ST_COUNT;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) state <= ST_COUNT;
        else state <= next_state;
    end

    // Validity latch; a dropout wins over a simultaneous arm
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            valid <= 1'b0; // see R16
        end else if (!qual_hold.wide) begin
            valid <= 1'b0; // see R12
        end else if (detector_arm_strobe_i) begin
            valid <= 1'b1; // see R11
        end
    end

    // Detector bus: data and enable both stand in the cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            data_o    <= 8'h00;
            data_oe_o <= 1'b0;
        end else begin
            data_oe_o <= detector_read_strobe_i; // see R9
            data_o    <= 8'h00;
            data_o[`IFQ_BIT_VALID]    <= valid; // see R13
            data_o[`IFQ_BIT_NARROW_N] <= ~qual_hold.narrow; // see R10
            data_o[`IFQ_BIT_OVERLOAD] <= input_overload_flag_i; // see R15
        end
    end

    // Edge history for interrupt events
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            valid_q  <= 1'b0;
            narrow_q <= 1'b0;
            ovl_q    <= 1'b0;
        end else begin
            valid_q  <= valid;
            narrow_q <= qual_hold.narrow;
            ovl_q    <= input_overload_flag_i;
        end
    end

    assign irq_event[`IFQ_IRQ_NARROW]   = qual_hold.narrow & ~narrow_q;
    assign irq_event[`IFQ_IRQ_INVALID]  = ~valid & valid_q;
    assign irq_event[`IFQ_IRQ_OVERLOAD] = input_overload_flag_i & ~ovl_q;
    assign irq_clear = (reg_wr_i && reg_addr_i == `IFQ_REG_IRQ_STATUS) ? reg_wdata_i[2:0] : 3'h0;

    // Sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) irq_status <= 3'h0;
        else irq_status <= (irq_status & ~irq_clear) | irq_event;
    end

    // Interrupt mask
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            irq_mask <= `IFQ_IRQ_MASK_RESET;
        end else if (reg_wr_i && reg_addr_i == `IFQ_REG_IRQ_MASK) begin
            irq_mask <= reg_wdata_i[2:0];
        end
    end

    assign irq_o = |(irq_status & irq_mask);

    // Register read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `IFQ_REG_IRQ_STATUS: reg_rdata_o <= {5'h00, irq_status};
                `IFQ_REG_IRQ_MASK:   reg_rdata_o <= {5'h00, irq_mask};
                `IFQ_REG_LIVE:       reg_rdata_o <= {valid, qual_hold.narrow, qual_hold.wide,
                                                     input_overload_flag_i, 4'h0};
                default:             reg_rdata_o <= 8'h00;
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    // Checking helpers: raw IF edges modulo four
    logic       if_h;
    logic [1:0] if_edges;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            if_h     <= 1'b0;
            if_edges <= 2'h0;
        end else begin
            if_h <= if_i;
            if (if_i && !if_h) if_edges <= if_edges + 2'h1;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence seq_arm;
        detector_arm_strobe_i && qual_hold.wide;
    endsequence

    sequence seq_armed;
        ##1 valid;
    endsequence

    a_prescale_ratio: assert property (tick |-> (if_i && !if_h && if_edges == 2'h3)) // see R1
        else $error("prescaler tick not on every fourth IF edge");
    a_gate_phase: assert property (timing.gate |-> timing.phase < 3'h4) // see R2
        else $error("gate open outside first four reference periods");
    a_count_frozen: assert property (!timing.gate && !timing.clear |=> $stable(count)) // see R3
        else $error("counter moved with gate closed");
    a_count_step: assert property (timing.gate && tick && !timing.clear && count != CNT_MAX
                                   |=> count == $past(count) + CNT_W'(1)) // see R3
        else $error("counter missed a gated tick");
    a_load_capture: assert property (timing.load |=> qual_hold == $past(next_qual)) // see R7
        else $error("holding register not loaded from decode");
    a_narrow_range: assert property (timing.load && count >= 8'h30 && count <= 8'h66
                                     |=> qual_hold.narrow) // see R5
        else $error("narrow qualifier false for in-range count");
    a_wide_range: assert property (timing.load && (count < 8'h16 || count > 8'h80)
                                   |=> !qual_hold.wide) // see R6
        else $error("wide qualifier true out of range");
    a_clear_delay: assert property (timing.clear |-> timing.phase == 3'h4 ##1 count == '0) // see R8
        else $error("counter not cleared one period after load");
    a_read_drive: assert property (detector_read_strobe_i |=> data_oe_o) // see R9
        else $error("driver not enabled after read strobe");
    a_read_release: assert property (!detector_read_strobe_i |=> !data_oe_o) // see R9
        else $error("driver enabled without read strobe");
    a_d6_level: assert property (1'b1 |=> data_o[6] == !$past(qual_hold.narrow)) // see R10
        else $error("D6 does not show narrow qualifier low-true");
    a_arm_valid: assert property (seq_arm |-> seq_armed) // see R11
        else $error("arm strobe failed to set validity latch");
    a_valid_drop: assert property (!qual_hold.wide
                                   |=> !valid ##1 (!valid || $past(detector_arm_strobe_i && qual_hold.wide))) // see R12
        else $error("validity latch survived wide qualifier loss");
    a_d7_d4: assert property (1'b1 |=> data_o[7] == $past(valid) && data_o[4] == $past(input_overload_flag_i)) // see R13 see R15
        else $error("D7 or D4 does not follow its source");
    a_hold_closed: assert property (state == ST_HOLD |-> !timing.gate && timing.phase == 3'h4) // see R8
        else $error("hold state seen while gate open");
endmodule
`default_nettype wire

// File: test/ifq_host_model.sv
// Host model that drives the detector strobes and samples the detector bus
`timescale 1ns/1ps
`default_nettype none
module ifq_host_model (
    // Clock
    input  wire logic       clk_i,
    // Detector data bus
    input  wire logic [7:0] data_i,
    input  wire logic       data_oe_i,
    output logic            det_rd_o,
    output logic            det_arm_o
);
    logic [7:0] last_bus    = 8'h00;
    logic [7:0] bus;
    logic       sweeping    = 1'b1;
    logic       dashes      = 1'b0;
    int         stop_khz    = 0;
    int         restart_khz = 0;

    // A released bus floats, so show the inverse of the last byte driven
    assign bus = data_oe_i ? data_i : ~last_bus;
    always @(posedge clk_i) begin
        if (data_oe_i) begin
            last_bus <= data_i;
        end
    end

    initial begin
        det_rd_o  = 1'b0;
        det_arm_o = 1'b0;
    end

    // One read strobe; the byte is taken in the cycle after the strobe
    task automatic read_det(output logic [7:0] v, output logic oe);
        @(posedge clk_i);
        det_rd_o <= 1'b1;
        @(posedge clk_i);
        det_rd_o <= 1'b0;
        @(posedge clk_i);
        oe = data_oe_i;
        v  = bus;
        if (!v[6]) begin
            sweeping = 1'b0;
        end
        if (!v[7] && !sweeping) begin
            restart_khz = stop_khz - 100;
        end
        dashes = v[4];
    endtask

    // Arm pulse, issued once the sweep has stopped
    task automatic arm_det();
        @(posedge clk_i);
        det_arm_o <= 1'b1;
        @(posedge clk_i);
        det_arm_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench for the IF frequency window qualifier
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // Reference slowed down so the IF stays under half the clock rate
    localparam int HALF_REF = 128;
    localparam int MEAS     = 32 * HALF_REF;
    localparam int LIMIT    = 40000;

    logic       clk_i     = 1'b0;
    logic       sys_rst_i = 1'b1;
    logic       ref_q     = 1'b0;
    logic       if_q      = 1'b0;
    logic       pwr_ok    = 1'b1;
    logic       ovl       = 1'b0;
    logic [1:0] reg_addr  = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr    = 1'b0;
    logic       reg_rd    = 1'b0;
    logic [7:0] reg_rdata;
    logic [7:0] data;
    logic       data_oe;
    logic       det_rd;
    logic       det_arm;
    logic       irq;
    logic [7:0] v;
    int         if_period = 0;
    int         ref_cnt   = 0;
    int         if_cnt    = 0;
    int         cycles    = 0;
    int         fail_count = 0;
    int         compares  = 0;

    ifq_top dut (
        .clk_i                  (clk_i),
        .sys_rst_i              (sys_rst_i),
        .if_i                   (if_q),
        .ref_1mhz_i             (ref_q),
        .input_power_ok_i       (pwr_ok),
        .input_overload_flag_i  (ovl),
        .detector_read_strobe_i (det_rd),
        .detector_arm_strobe_i  (det_arm),
        .data_o                 (data),
        .data_oe_o              (data_oe),
        .reg_addr_i             (reg_addr),
        .reg_wdata_i            (reg_wdata),
        .reg_wr_i               (reg_wr),
        .reg_rd_i               (reg_rd),
        .reg_rdata_o            (reg_rdata),
        .irq_o                  (irq)
    );

    ifq_host_model host (
        .clk_i     (clk_i),
        .data_i    (data),
        .data_oe_i (data_oe),
        .det_rd_o  (det_rd),
        .det_arm_o (det_arm)
    );

    // 40 MHz clock
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    // Free-running reference and IF sources, plus the hang guard
    always @(posedge clk_i) begin
        ref_cnt <= (ref_cnt == HALF_REF - 1) ? 0 : ref_cnt + 1;
        if (ref_cnt == HALF_REF - 1) begin
            ref_q <= ~ref_q;
        end
        if_cnt <= (if_cnt >= if_period / 2 - 1) ? 0 : if_cnt + 1;
        if (if_period != 0 && if_cnt >= if_period / 2 - 1) begin
            if_q <= ~if_q;
        end
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fail_count++;
            close_out();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_i);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk_i);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_i);
        reg_rd <= 1'b0;
        @(posedge clk_i);
        d = reg_rdata;
    endtask

    // Detector read through the host, then the driver must let go
    task automatic det_read(input logic [7:0] exp);
        logic seen_oe;
        host.read_det(v, seen_oe);
        check({7'h00, seen_oe}, 8'h01);
        check(v, exp);
        #1;
        check({7'h00, data_oe}, 8'h00);
    endtask

    task automatic irq_is(input logic exp);
        #1;
        check({7'h00, irq}, {7'h00, exp});
    endtask

    task automatic new_if(input int p);
        @(posedge clk_i);
        if_period <= p;
        repeat (MEAS) @(posedge clk_i);
    endtask

    task automatic close_out();
        if (fail_count == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        // Quiet after reset, unmapped address reads zero
        for (int a = 0; a < 4; a++) begin
            reg_read(2'(a), v);
            check(v, 8'h00);
        end
        det_read(8'h40);
        // Overload flag, its event, mask and clear
        @(posedge clk_i);
        ovl <= 1'b1;
        det_read(8'h50);
        check({7'h00, host.dashes}, 8'h01);
        reg_read(2'h0, v);
        check(v, 8'h04);
        irq_is(1'b0);
        reg_write(2'h1, 8'h07);
        irq_is(1'b1);
        reg_write(2'h0, 8'h04);
        irq_is(1'b0);
        reg_read(2'h1, v);
        check(v, 8'h07);
        @(posedge clk_i);
        ovl <= 1'b0;
        // 64 counts: narrow and wide in range, then arm
        new_if(4);
        det_read(8'h00);
        check({7'h00, host.sweeping}, 8'h00);
        host.arm_det();
        det_read(8'h80);
        reg_read(2'h2, v);
        check(v, 8'hE0);
        reg_read(2'h0, v);
        check(v, 8'h01);
        reg_write(2'h0, 8'h01);
        irq_is(1'b0);
        // 32 counts: wide only, latch survives repeated cycles
        new_if(8);
        det_read(8'hC0);
        reg_read(2'h2, v);
        check(v, 8'hA0);
        // 16 counts: out of range drops the latch, arm refused
        new_if(16);
        det_read(8'h40);
        reg_read(2'h0, v);
        check(v, 8'h02);
        irq_is(1'b1);
        reg_write(2'h0, 8'h02);
        irq_is(1'b0);
        host.arm_det();
        det_read(8'h40);
        // Power loss drops the latch while narrow stays true
        new_if(4);
        host.arm_det();
        det_read(8'h80);
        @(posedge clk_i);
        pwr_ok <= 1'b0;
        repeat (MEAS) @(posedge clk_i);
        det_read(8'h00);
        // Second reset in mid-run
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        pwr_ok    <= 1'b1;
        @(posedge clk_i);
        sys_rst_i <= 1'b0;
        reg_read(2'h2, v);
        check(v, 8'h00);
        reg_read(2'h1, v);
        check(v, 8'h00);
        close_out();
    end
endmodule
`default_nettype wire
